// ===== core/css_pkg.sv
// constants and carrier types for the channel serial, slot, indirect ram and status block
// -----------------------------------------------------------------------------
// Overview of operation
// - in-phase 10-bit slot counter, serial clock rate
// - both slot counters restart on frame strobe
// - quadrature 10-bit slot counter, carry marks symbol
// - vector mode pushes only after both symbols
// - frequency mode pushes in-phase symbol at once
// - symbol order follows programmed slot values
// - 16-bit indirect data register at 0x14
// - address register 0x15, msb one means read
// - bit 11 after 24 reads while off-line
// - bits 10/9 in-phase filter saturation flags
// - bits 8/7 quadrature filter saturation flags
// - bits 6:4 show fifo fill level
// - bit 3 flags read of empty fifo
// - bit 2 flags fifo level seven
// - bit 1 flags level below almost-empty threshold
// - bit 0 flags fifo level zero
// - error bits or-ed and latched for top
// - nine status bits latched until cleared; bits 6:4 stay live
// - top status write clears channel status
// - fifo overflow forces channel off-line
// - flushed status 24 sample reads after off-line
// - frame strobe polarity selects active edge
// -----------------------------------------------------------------------------
package css_pkg;

    localparam logic [7:0] OFS_I_SLOT = 8'h12;
    localparam logic [7:0] OFS_Q_SLOT = 8'h13;
    localparam logic [7:0] OFS_RAM_DATA = 8'h14;
    localparam logic [7:0] OFS_RAM_ADDR = 8'h15;
    localparam logic [7:0] OFS_STATUS = 8'h16;

    localparam int SLOT_W = 10;
    localparam logic [9:0] SLOT_RESET = 10'h000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int RAM_READ_BIT = 15;

    localparam int ST_FLUSHED = 11;
    localparam int ST_I_POS = 10;
    localparam int ST_I_NEG = 9;
    localparam int ST_Q_POS = 8;
    localparam int ST_Q_NEG = 7;
    localparam int ST_LEVEL_LO = 4;
    localparam int ST_UNDER = 3;
    localparam int ST_OVER = 2;
    localparam int ST_AEMPTY = 1;
    localparam int ST_EMPTY = 0;
    localparam logic [11:0] ST_ERR_MASK = 12'h788;
    localparam logic [11:0] ST_RESET = 12'h000;

    localparam logic [4:0] FLUSH_READS = 5'h18;
    localparam logic [2:0] FIFO_FULL_LEVEL = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } css_cpu_req_type;

    typedef struct packed {
        logic i_pos;
        logic i_neg;
        logic q_pos;
        logic q_neg;
    } css_sat_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [14:0] addr;
        logic [15:0] wdata;
    } css_ram_req_type;

endpackage

// ===== core/css_sync.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module css_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // ---------------------------------------------------------------
    // stages: edges look only at the second and third flop
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign q = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule // css_sync

// ===== core/css_fifo.sv
// small circular symbol fifo with a read pointer kept apart from its fill level
`timescale 1ns/1ps
module css_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 7
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    output logic [2:0] level
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [2:0] wp_reg, wp_next, rp_reg, rp_next, lvl_reg, lvl_next;
    logic [WIDTH-1:0] out_reg, out_next;
    logic do_push, do_pop;

    // a push into a full fifo is dropped; the owner flags overflow as soon as the level is full
    always_comb
    begin
        do_push = push && (lvl_reg != 3'(DEPTH));
        do_pop = pop && (lvl_reg != 3'h0);
        wp_next = do_push ? ((wp_reg == 3'(DEPTH - 1)) ? 3'h0 : wp_reg + 3'h1) : wp_reg;
        rp_next = do_pop ? ((rp_reg == 3'(DEPTH - 1)) ? 3'h0 : rp_reg + 3'h1) : rp_reg;
        lvl_next = lvl_reg + {2'h0, do_push} - {2'h0, do_pop};
        out_next = do_pop ? mem_reg[rp_reg] : out_reg;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_reg <= 3'h0;
            rp_reg <= 3'h0;
            lvl_reg <= 3'h0;
            out_reg <= '0;
            for (int k = 0; k < DEPTH; k++)
                mem_reg[k] <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            lvl_reg <= lvl_next;
            out_reg <= out_next;
            if (do_push)
                mem_reg[wp_reg] <= push_data;
        end
    end

    assign pop_data = out_reg;
    assign level = lvl_reg;
endmodule // css_fifo

// ===== core/css_channel.sv
// one channel: serial symbol capture, indirect ram port and sticky status
`timescale 1ns/1ps
module css_channel (
    input wire logic clock,
    input wire logic rstn,
    input wire css_pkg::css_cpu_req_type cpu_req,
    output logic [15:0] cpu_rdata,
    input wire logic serial_clk,
    input wire logic serial_frame_sync,
    input wire logic serial_data,
    input wire logic fsync_polarity,
    input wire logic vector_modulation_mode,
    input wire logic channel_online,
    input wire logic [2:0] almost_empty_threshold,
    input wire logic sample_rd,
    output logic [31:0] sym_data,
    input wire css_pkg::css_sat_type filter_sat,
    input wire logic top_status_wr,
    output logic top_error,
    output logic channel_offline,
    output css_pkg::css_ram_req_type ram_req,
    input wire logic [15:0] ram_rdata
);
    import css_pkg::*;

    typedef enum logic [0:0] {RAM_IDLE, RAM_WAIT} css_ram_state_type;

    // carry decode shared by both slot counters
    function automatic logic slot_carry(input logic [SLOT_W-1:0] cnt, input logic run, input logic tick);
        slot_carry = run && tick && (cnt == {SLOT_W{1'b1}});
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pin_q, pin_rise, pin_fall;

    css_sync #(.W(3)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d({serial_data, serial_frame_sync, serial_clk}),
        .q(pin_q),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic sclk_tick, frame_start;
    assign sclk_tick = pin_rise[0];
    assign frame_start = fsync_polarity ? pin_fall[1] : pin_rise[1];

    // ---------------------------------------------------------------
    // registers reached over the host port
    // ---------------------------------------------------------------
    logic [SLOT_W-1:0] slot_reg [2];
    logic [SLOT_W-1:0] slot_next [2];
    logic [15:0] ram_data_reg, ram_data_next, ram_addr_reg, ram_addr_next, rdata_reg, rdata_next;
    css_ram_req_type ram_req_reg, ram_req_next;
    css_ram_state_type ram_st_reg, ram_st_next;
    logic [11:0] status_reg, status_next;

    // register writes, read mux and indirect ram sequencing
    always_comb
    begin
        slot_next = slot_reg;
        ram_data_next = ram_data_reg;
        ram_addr_next = ram_addr_reg;
        ram_st_next = ram_st_reg;
        ram_req_next = ram_req_reg;
        ram_req_next.wr = 1'b0;
        ram_req_next.rd = 1'b0;
        rdata_next = rdata_reg;
        if (cpu_req.wr)
        begin
            case (cpu_req.addr)
                OFS_I_SLOT: slot_next[0] = cpu_req.wdata[SLOT_W-1:0];
                OFS_Q_SLOT: slot_next[1] = cpu_req.wdata[SLOT_W-1:0];
                OFS_RAM_DATA: ram_data_next = cpu_req.wdata;
                OFS_RAM_ADDR:
                begin
                    ram_addr_next = cpu_req.wdata;
                    ram_req_next.addr = cpu_req.wdata[14:0];
                    ram_req_next.wdata = ram_data_reg;
                    // the top address bit picks the access type
                    ram_req_next.rd = cpu_req.wdata[RAM_READ_BIT];
                    ram_req_next.wr = !cpu_req.wdata[RAM_READ_BIT];
                    ram_st_next = cpu_req.wdata[RAM_READ_BIT] ? RAM_WAIT : RAM_IDLE;
                end
                default: ;
            endcase
        end
        case (ram_st_reg)
            RAM_IDLE: ;
            // read data is taken in the strobe cycle; it lands in the data register one edge later
            RAM_WAIT:
            begin
                ram_data_next = ram_rdata;
                ram_st_next = RAM_IDLE;
            end
            default: ram_st_next = RAM_IDLE;
        endcase
        if (cpu_req.rd)
        begin
            case (cpu_req.addr)
                OFS_I_SLOT: rdata_next = {6'h00, slot_reg[0]};
                OFS_Q_SLOT: rdata_next = {6'h00, slot_reg[1]};
                OFS_RAM_DATA: rdata_next = ram_data_reg;
                OFS_RAM_ADDR: rdata_next = ram_addr_reg;
                OFS_STATUS: rdata_next = {4'h0, status_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            slot_reg[0] <= SLOT_RESET;
            slot_reg[1] <= SLOT_RESET;
            ram_data_reg <= REG_RESET;
            ram_addr_reg <= REG_RESET;
            rdata_reg <= REG_RESET;
            ram_req_reg <= '0;
            ram_st_reg <= RAM_IDLE;
        end
        else
        begin
            slot_reg <= slot_next;
            ram_data_reg <= ram_data_next;
            ram_addr_reg <= ram_addr_next;
            rdata_reg <= rdata_next;
            ram_req_reg <= ram_req_next;
            ram_st_reg <= ram_st_next;
        end
    end

    assign cpu_rdata = rdata_reg;
    assign ram_req = ram_req_reg;

    // ---------------------------------------------------------------
    // slot counters and symbol capture
    // ---------------------------------------------------------------
    logic [SLOT_W-1:0] cnt_reg [2];
    logic [SLOT_W-1:0] cnt_next [2];
    logic [1:0] run_reg, run_next, have_reg, have_next, carry;
    logic [15:0] shift_reg, shift_next;
    logic [15:0] sym_reg [2];
    logic [15:0] sym_next [2];
    logic sym_push, i_first;
    logic [31:0] push_word;

    // the counter loaded with the larger slot value carries first
    assign i_first = slot_reg[0] >= slot_reg[1];

    // each counter loads its slot at frame start and carries at all ones
    always_comb
    begin
        shift_next = sclk_tick ? {shift_reg[14:0], pin_q[2]} : shift_reg;
        cnt_next = cnt_reg;
        run_next = run_reg;
        sym_next = sym_reg;
        have_next = have_reg;
        for (int c = 0; c < 2; c++)
        begin
            carry[c] = slot_carry(cnt_reg[c], run_reg[c], sclk_tick);
            if (frame_start)
            begin
                cnt_next[c] = slot_reg[c];
                run_next[c] = 1'b1;
            end
            else if (carry[c])
            begin
                run_next[c] = 1'b0;
                sym_next[c] = shift_next;
            end
            else if (run_reg[c] && sclk_tick)
                cnt_next[c] = cnt_reg[c] + 10'h001;
        end
        // vector mode waits for both halves, frequency mode only for in-phase
        if (vector_modulation_mode)
            sym_push = (have_reg[0] || carry[0]) && (have_reg[1] || carry[1]);
        else
            sym_push = carry[0];
        if (sym_push)
            have_next = 2'b00;
        else if (vector_modulation_mode)
            have_next = have_reg | carry;
        push_word = vector_modulation_mode ? {sym_next[0], sym_next[1]} : {sym_next[0], 16'h0000};
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_reg <= 16'h0000;
            cnt_reg[0] <= SLOT_RESET;
            cnt_reg[1] <= SLOT_RESET;
            run_reg <= 2'b00;
            have_reg <= 2'b00;
            sym_reg[0] <= 16'h0000;
            sym_reg[1] <= 16'h0000;
        end
        else
        begin
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            have_reg <= have_next;
            sym_reg <= sym_next;
        end
    end

    // ---------------------------------------------------------------
    // input fifo
    // ---------------------------------------------------------------
    logic [2:0] level;

    css_fifo #(.WIDTH(32), .DEPTH(7)) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .push(sym_push),
        .push_data(push_word),
        .pop(sample_rd),
        .pop_data(sym_data),
        .level(level)
    );

    // ---------------------------------------------------------------
    // off-line, flush count and sticky status
    // ---------------------------------------------------------------
    logic auto_off_reg, auto_off_next, offline;
    logic [4:0] flush_reg, flush_next;
    logic [11:0] live;
    logic err_reg, err_next;

    assign offline = !channel_online || auto_off_reg;

    // overflow holds the channel off-line until software drops the on-line bit
    always_comb
    begin
        auto_off_next = auto_off_reg;
        if (level == FIFO_FULL_LEVEL)
            auto_off_next = 1'b1;
        else if (!channel_online)
            auto_off_next = 1'b0;
        flush_next = flush_reg;
        if (!offline)
            flush_next = 5'h00;
        else if (sample_rd && flush_reg != FLUSH_READS)
            flush_next = flush_reg + 5'h01;
        live = 12'h000;
        live[ST_FLUSHED] = flush_reg == FLUSH_READS;
        live[ST_I_POS] = filter_sat.i_pos;
        live[ST_I_NEG] = filter_sat.i_neg;
        live[ST_Q_POS] = filter_sat.q_pos;
        live[ST_Q_NEG] = filter_sat.q_neg;
        live[ST_UNDER] = sample_rd && (level == 3'h0) && !sym_push;
        live[ST_OVER] = level == FIFO_FULL_LEVEL;
        live[ST_AEMPTY] = level < almost_empty_threshold;
        live[ST_EMPTY] = level == 3'h0;
        // a new event in the clearing cycle survives the clear
        status_next = (top_status_wr ? ST_RESET : status_reg) | live;
        // the fill level is a live field, not an or of past values
        status_next[ST_LEVEL_LO +: 3] = level;
        err_next = |(status_next & ST_ERR_MASK);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            auto_off_reg <= 1'b0;
            flush_reg <= 5'h00;
            status_reg <= ST_RESET;
            err_reg <= 1'b0;
        end
        else
        begin
            auto_off_reg <= auto_off_next;
            flush_reg <= flush_next;
            status_reg <= status_next;
            err_reg <= err_next;
        end
    end

    assign top_error = err_reg;
    assign channel_offline = offline;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_read_start;
        cpu_req.wr && cpu_req.addr == OFS_RAM_ADDR && cpu_req.wdata[RAM_READ_BIT];
    endsequence
    sequence s_read_finish;
        ram_req.rd ##1 (ram_data_reg == $past(ram_rdata));
    endsequence

    chk_frame_reload: assert property (frame_start |=> cnt_reg[0] == $past(slot_reg[0]) && run_reg == 2'b11)
        else $error("slot counter not reloaded at frame start");
    chk_fm_push: assert property (!vector_modulation_mode && carry[0] |-> sym_push)
        else $error("frequency mode symbol not pushed");
    chk_vector_pair: assert property (vector_modulation_mode && sym_push |-> (have_reg | carry) == 2'b11)
        else $error("vector push without both symbols");
    chk_ram_read: assert property (s_read_start |=> s_read_finish)
        else $error("indirect read not carried out");
    chk_ram_write: assert property (cpu_req.wr && cpu_req.addr == OFS_RAM_ADDR && !cpu_req.wdata[RAM_READ_BIT]
        |=> ram_req.wr && !ram_req.rd)
        else $error("indirect write not issued");
    chk_over_offline: assert property (level == FIFO_FULL_LEVEL |=> channel_offline && status_reg[ST_OVER])
        else $error("overflow did not force off-line");
    chk_under_flag: assert property (sample_rd && level == 3'h0 && !sym_push |=> status_reg[ST_UNDER])
        else $error("underflow not flagged");
    chk_flush_count: assert property (offline && sample_rd && flush_reg == 5'h17 ##1 offline
        |=> status_reg[ST_FLUSHED])
        else $error("flushed not set after 24 reads");
    // the summary flop and the sticky bits are loaded at the same edge, so they must always agree
    chk_error_summary: assert property (top_error == |(status_reg & ST_ERR_MASK))
        else $error("top error summary mismatch");
    chk_slot_reserved: assert property (cpu_req.rd && cpu_req.addr == OFS_I_SLOT |=> cpu_rdata[15:10] == 6'h00)
        else $error("reserved slot bits not zero");
    chk_status_reserved: assert property (cpu_req.rd && cpu_req.addr == OFS_STATUS
        |=> cpu_rdata[15:12] == 4'h0)
        else $error("reserved status bits not zero");

    // flag and field checks: each looks one edge after the condition that sets it
    chk_level_field: assert property (1'b1 |=> status_reg[ST_LEVEL_LO +: 3] == $past(level))
        else $error("status level field does not follow the fifo");
    chk_empty_flag: assert property (level == 3'h0 |=> status_reg[ST_EMPTY])
        else $error("empty flag not set");
    chk_aempty_flag: assert property (level < almost_empty_threshold |=> status_reg[ST_AEMPTY])
        else $error("almost-empty flag not set");
    chk_ipos_sat: assert property (filter_sat.i_pos |=> status_reg[ST_I_POS] && top_error)
        else $error("in-phase saturation not flagged");
    chk_qneg_sat: assert property (filter_sat.q_neg |=> status_reg[ST_Q_NEG] && top_error)
        else $error("quadrature saturation not flagged");
    // a sticky bit must survive every cycle that has no clear in it
    chk_under_sticky: assert property (status_reg[ST_UNDER] && !top_status_wr |=> status_reg[ST_UNDER])
        else $error("underflow flag lost without a clear");
    chk_status_clear: assert property (top_status_wr |=> status_reg[11:7] == $past(live[11:7])
        && status_reg[3:0] == $past(live[3:0]))
        else $error("status not cleared by top write");

    // the half that arrived first must be the one with the larger slot value
    chk_i_before_q: assert property (vector_modulation_mode && carry[1] && !carry[0] && have_reg[0]
        |-> i_first)
        else $error("in-phase arrived first against the slot order");
    chk_q_before_i: assert property (vector_modulation_mode && carry[0] && !carry[1] && have_reg[1]
        |-> !i_first)
        else $error("quadrature arrived first against the slot order");
endmodule // css_channel

// ===== testbench/css_serial_src.sv
// behavioural serial symbol source driving one channel's serial pins
`timescale 1ns/1ps
module css_serial_src (
    input wire logic pol,
    output logic sclk,
    output logic fsync,
    output logic sdata
);
    logic strobe = 1'b0;

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    // the strobe idles at the inactive level of the chosen polarity
    assign fsync = pol ^ strobe;
    initial
    begin
        sclk = 1'b0;
        sdata = 1'b0;
    end

    // one frame: strobe edge, then both words msb first, 48 ns per bit
    task automatic send(input logic [15:0] w0, input logic [15:0] w1);
        logic [31:0] bits;
        bits = {w0, w1};
        strobe = 1'b1;
        #24;
        strobe = 1'b0;
        #24;
        for (int i = 31; i >= 0; i--)
        begin
            sdata = bits[i];
            #24;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        // clock stands still between frames; a released line must not look held
        sdata = ~sdata;
    endtask
endmodule // css_serial_src

// ===== testbench/css_channel_test.sv
// self-checking bench for serial capture, indirect ram port and sticky status
`timescale 1ns/1ps
module css_channel_test;
    import css_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    css_cpu_req_type cpu_req = '0;
    logic [15:0] cpu_rdata;
    logic sclk;
    logic fsync;
    logic sdata;
    logic pol = 1'b0;
    logic vmode = 1'b1;
    logic online = 1'b1;
    logic sample_rd = 1'b0;
    logic [31:0] sym_data;
    css_sat_type filter_sat = '0;
    logic top_status_wr = 1'b0;
    logic top_error;
    logic channel_offline;
    css_ram_req_type ram_req;
    logic [15:0] ram_rdata = 16'h5a3c;
    logic [39:0] got;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2 clock = ~clock;

    css_channel DUT (
        .clock(clock),
        .rstn(rstn),
        .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata),
        .serial_clk(sclk),
        .serial_frame_sync(fsync),
        .serial_data(sdata),
        .fsync_polarity(pol),
        .vector_modulation_mode(vmode),
        .channel_online(online),
        .almost_empty_threshold(3'h3),
        .sample_rd(sample_rd),
        .sym_data(sym_data),
        .filter_sat(filter_sat),
        .top_status_wr(top_status_wr),
        .top_error(top_error),
        .channel_offline(channel_offline),
        .ram_req(ram_req),
        .ram_rdata(ram_rdata)
    );

    css_serial_src src (
        .pol(pol),
        .sclk(sclk),
        .fsync(fsync),
        .sdata(sdata)
    );

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [39:0] act, input logic [39:0] exp);
        n_checks++;
        if (act !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic host_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        cpu_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        cpu_req <= '0;
    endtask

    // read data lands at the taking edge; sample once it has settled
    task automatic host_rd(input logic [7:0] a);
        @(posedge clock);
        cpu_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock);
        cpu_req <= '0;
        #1;
        got = 40'(cpu_rdata);
    endtask

    task automatic pulse_rd(input int n);
        repeat (n)
        begin
            @(posedge clock);
            sample_rd <= 1'b1;
            @(posedge clock);
            sample_rd <= 1'b0;
        end
        #1;
    endtask

    task automatic clear_status();
        @(posedge clock);
        top_status_wr <= 1'b1;
        @(posedge clock);
        top_status_wr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // leave room for the pin synchronisers before the next step
    task automatic frame(input logic [15:0] w0, input logic [15:0] w1);
        src.send(w0, w1);
        repeat (10) @(posedge clock);
    endtask

    // ---------------------------------------------------------------
    // hang guard: the whole sequence needs well under 20000 cycles
    // ---------------------------------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 18; a < 22; a++)
        begin
            host_rd(8'(a));
            check(got, 40'h0);
        end
        host_wr(OFS_I_SLOT, 16'hffff);
        host_rd(OFS_I_SLOT);
        check(got, 40'h03ff);
        host_wr(OFS_Q_SLOT, 16'hffff);
        host_rd(OFS_Q_SLOT);
        check(got, 40'h03ff);
        host_rd(8'h20);
        check(got, 40'h0);
        // status is read only; empty and almost-empty hold after reset
        host_wr(OFS_STATUS, 16'hffff);
        host_rd(OFS_STATUS);
        check(got, 40'h0003);
        check(40'(top_error), 40'h0);
        // indirect write, then indirect read
        host_wr(OFS_RAM_DATA, 16'ha5c3);
        host_wr(OFS_RAM_ADDR, 16'h0005);
        #1;
        check(40'(ram_req), {7'h0, 2'b10, 15'h0005, 16'ha5c3});
        host_wr(OFS_RAM_ADDR, 16'h8009);
        #1;
        check(40'(ram_req), {7'h0, 2'b01, 15'h0009, 16'ha5c3});
        host_rd(OFS_RAM_DATA);
        check(got, 40'h5a3c);
        // vector mode, in-phase slot earlier in the frame
        host_wr(OFS_I_SLOT, 16'h03f0);
        host_wr(OFS_Q_SLOT, 16'h03e0);
        frame(16'h1234, 16'habcd);
        clear_status();
        host_rd(OFS_STATUS);
        check(got, 40'h0012);
        pulse_rd(1);
        check(40'(sym_data), 40'h1234abcd);
        // swapped slots: quadrature word arrives first
        host_wr(OFS_I_SLOT, 16'h03e0);
        host_wr(OFS_Q_SLOT, 16'h03f0);
        frame(16'h0f0f, 16'hc3a5);
        pulse_rd(1);
        check(40'(sym_data), 40'hc3a50f0f);
        // frequency mode with falling-edge strobe; quadrature word is ignored
        @(posedge clock);
        pol <= 1'b1;
        vmode <= 1'b0;
        repeat (8) @(posedge clock);
        frame(16'h0f0f, 16'h7e81);
        clear_status();
        host_rd(OFS_STATUS);
        check(got, 40'h0012);
        pulse_rd(1);
        check(40'(sym_data), 40'h7e810000);
        @(posedge clock);
        pol <= 1'b0;
        vmode <= 1'b1;
        repeat (8) @(posedge clock);
        // underflow is sticky and reaches the top error
        clear_status();
        pulse_rd(1);
        host_rd(OFS_STATUS);
        check(got, 40'h000b);
        check(40'(top_error), 40'h1);
        clear_status();
        check(40'(top_error), 40'h0);
        // each filter saturation flag in turn
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clock);
            filter_sat <= css_sat_type'(4'h8 >> k);
            @(posedge clock);
            filter_sat <= '0;
            host_rd(OFS_STATUS);
            check(got, 40'((16'h0400 >> k) | 16'h0003));
            check(40'(top_error), 40'h1);
            clear_status();
        end
        // fill to seven: overflow forces off-line, then flush count
        repeat (7) frame(16'h1111, 16'h2222);
        clear_status();
        host_rd(OFS_STATUS);
        check(got, 40'h0074);
        check(40'(channel_offline), 40'h1);
        pulse_rd(23);
        host_rd(OFS_STATUS);
        check(40'(got[11]), 40'h0);
        pulse_rd(1);
        host_rd(OFS_STATUS);
        check(40'(got[11]), 40'h1);
        @(posedge clock);
        online <= 1'b0;
        @(posedge clock);
        online <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(40'(channel_offline), 40'h0);
        conclude();
    end
endmodule // css_channel_test
